//--- hw/rtc_cfg.svh
// Offsets, field positions, reset values and timing counts of the clock block
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH

`define RTC_ADDR_W        3
`define RTC_OFS_SECONDS   3'h0
`define RTC_OFS_MINUTES   3'h1
`define RTC_OFS_HOURS     3'h2
`define RTC_OFS_WEEKDAY   3'h3
`define RTC_OFS_MAIN_CTRL 3'h4
`define RTC_OFS_PIC       3'h5
`define RTC_OFS_CSR       3'h6
`define RTC_OFS_FLAG      3'h7

`define MAIN_RUN_BIT      7
`define MAIN_H24_BIT      6
`define MAIN_PM_BIT       5
`define MAIN_SRST_BIT     4
`define PIC_OVF_BIT       5
`define PIC_WEEK_BIT      4
`define PIC_DAY_BIT       3
`define PIC_HOUR_BIT      2
`define PIC_MIN_BIT       1
`define PIC_SEC_BIT       0
`define PIC_MASK          8'h3f
`define CSR_MASK          8'h6f
`define CSR_TOP_BIT       3
`define CSR_OUT_LSB       5
`define WEEKDAY_BUSY_BIT  7
`define WEEKDAY_BAD       3'h7

`define CSR_RESET         8'h08
`define PIC_RESET         6'h00
`define MAIN_RESET        1'b0

`define RTC_TICK_HZ       32768
`define BUSY_TIME_US      62500
`define US_PER_SEC        1000000
`define RTC_BUSY_TICKS    ((`BUSY_TIME_US * `RTC_TICK_HZ) / `US_PER_SEC)

`endif

//--- hw/rtc_pkg.sv
// Types shared by the clock block modules
`default_nettype none
`include "rtc_cfg.svh"
package rtc_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [`RTC_ADDR_W-1:0] addr_t;
  typedef enum logic [1:0] {
    OUT_DIV4,
    OUT_DIV8,
    OUT_DIV16,
    OUT_DIV32
  } clkout_sel_e;
endpackage
`default_nettype wire

//--- hw/prescale_if.sv
// Link between the register logic and the system clock prescaler
`timescale 1ns/1ps
`default_nettype none
interface prescale_if;
  logic [2:0]          src_sel;
  rtc_pkg::clkout_sel_e out_sel;
  logic                src_tick;
  logic                clkout_level;
  modport ctrl (output src_sel, output out_sel, input src_tick, input clkout_level);
  modport div  (input src_sel, input out_sel, output src_tick, output clkout_level);
endinterface
`default_nettype wire

//--- hw/rtc_prescaler.sv
// System clock prescaler: counting ticks and the divided output clock level
`timescale 1ns/1ps
`default_nettype none
module rtc_prescaler (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic ce,
  prescale_if.div   pre
);
  import rtc_pkg::*;

  logic [12:0] div_reg;
  logic [12:0] div_next;
  logic [12:0] mask;

  always_comb begin
    div_next = div_reg + 13'h0001;
    unique case (pre.src_sel)
      3'h0: mask = 13'h0007;
      3'h1: mask = 13'h001f;
      3'h2: mask = 13'h007f;
      3'h3: mask = 13'h00ff;
      3'h4: mask = 13'h01ff;
      3'h5: mask = 13'h07ff;
      3'h6: mask = 13'h0fff;
      3'h7: mask = 13'h1fff;
    endcase
    pre.src_tick = ce && ((div_reg & mask) == mask);
    unique case (pre.out_sel)
      OUT_DIV4:  pre.clkout_level = div_reg[1];
      OUT_DIV8:  pre.clkout_level = div_reg[2];
      OUT_DIV16: pre.clkout_level = div_reg[3];
      OUT_DIV32: pre.clkout_level = div_reg[4];
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      div_reg <= 13'h0000;
    end else if (ce) begin
      div_reg <= div_next;
    end
  end
endmodule
`default_nettype wire

//--- hw/rtc_irq_clock_select.sv
// Clock block: periodic interrupts, clock source select, free-running counter
//
// How it works
// - Control bit 5 enables counter overflow interrupt.
// - Bits 4..0 enable week/day/hour/minute/second interrupts.
// - Control bits 7 and 6 read zero.
// - Output select 00 gives /4, 01 /8.
// - Divided output only in active or sleep.
// - Source codes 0..7 divide; top bit selects 32k.
// - Non-32k source turns block into 8-bit counter.
// - Run bit starts and stops the counter.
// - Seconds register reads counter in counter mode.
// - Enabled counter overflow sets shared flag.
// - Time registers survive the chip reset.
// - Busy set, about 62.5 ms later update, clear.
// - Enabled events set flag; writing 0 clears.
// - Week interrupt when weekday becomes zero.
// - Day/hour/minute/second interrupts on each advance.
// - Soft reset clears all but source and output select, the flag and its own bit.
// - Weekday codes 0..6; code 7 refused.
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_cfg.svh"
module rtc_irq_clock_select #(
  parameter int TICKS_PER_SEC = `RTC_TICK_HZ,
  parameter int BUSY_TICKS    = `RTC_BUSY_TICKS
) (
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire logic          ce,
  input  wire rtc_pkg::addr_t addr,
  input  wire rtc_pkg::byte_t wdata,
  input  wire logic          wr_en,
  input  wire logic          rd_en,
  output var  rtc_pkg::byte_t rdata,
  input  wire logic          rtc_tick,
  input  wire logic          chip_active,
  input  wire logic          clkout_pin_en,
  output var  logic          clock_output_pin,
  output var  logic          clock_irq_flag,
  output var  logic          update_busy_flag
);
  import rtc_pkg::*;

  localparam int SUB_W = $clog2(TICKS_PER_SEC);
  localparam logic [SUB_W-1:0] SUB_LAST   = SUB_W'(TICKS_PER_SEC - 1);
  localparam logic [SUB_W-1:0] BUSY_START = SUB_W'(TICKS_PER_SEC - BUSY_TICKS);

  if (TICKS_PER_SEC < 4 || BUSY_TICKS < 1 || BUSY_TICKS >= TICKS_PER_SEC) begin : g_bad_params
    $error("Tick counts out of range");
  end

  // Time group: no chip reset here, so time survives it
  logic [5:0] sec_reg;
  logic [5:0] sec_next;
  logic [5:0] min_reg;
  logic [5:0] min_next;
  logic [4:0] hour_reg;
  logic [4:0] hour_next;
  logic [2:0] dow_reg;
  logic [2:0] dow_next;
  logic       pm_reg;
  logic       pm_next;

  // Control group
  logic             run_reg;
  logic             run_next;
  logic             h24_reg;
  logic             h24_next;
  logic             srst_reg;
  logic             srst_next;
  logic [5:0]       pic_reg;
  logic [5:0]       pic_next;
  byte_t            csr_reg;
  byte_t            csr_next;
  byte_t            frc_reg;
  byte_t            frc_next;
  logic [SUB_W-1:0] sub_reg;
  logic [SUB_W-1:0] sub_next;
  logic             busy_reg;
  logic             busy_next;
  logic             flag_reg;
  logic             flag_next;
  byte_t            rdata_reg;
  byte_t            rdata_next;
  logic             clkout_reg;
  logic             clkout_next;

  logic free_mode;
  logic ev_ovf;
  logic ev_sec;
  logic ev_min;
  logic ev_hour;
  logic ev_day;
  logic ev_week;
  logic set_flag;

  prescale_if pre ();

  rtc_prescaler u_prescaler (
    .core_clk (core_clk),
    .rst      (rst),
    .ce       (ce),
    .pre      (pre)
  );

  assign pre.src_sel = csr_reg[2:0];
  assign pre.out_sel = clkout_sel_e'(csr_reg[`CSR_OUT_LSB +: 2]);

  always_comb begin
    sec_next    = sec_reg;
    min_next    = min_reg;
    hour_next   = hour_reg;
    dow_next    = dow_reg;
    pm_next     = pm_reg;
    run_next    = run_reg;
    h24_next    = h24_reg;
    srst_next   = srst_reg;
    pic_next    = pic_reg;
    csr_next    = csr_reg;
    frc_next    = frc_reg;
    sub_next    = sub_reg;
    busy_next   = busy_reg;
    flag_next   = flag_reg;
    rdata_next  = 8'h00;
    ev_ovf      = 1'b0;
    ev_sec      = 1'b0;
    ev_min      = 1'b0;
    ev_hour     = 1'b0;
    ev_day      = 1'b0;
    ev_week     = 1'b0;
    free_mode   = ~csr_reg[`CSR_TOP_BIT];

    if (free_mode) begin
      // Timekeeping stands still while the counter borrows the block
      busy_next = 1'b0;
      sub_next  = '0;
      if (run_reg && pre.src_tick) begin
        frc_next = frc_reg + 8'h01;
        ev_ovf   = (frc_reg == 8'hff);
      end
    end else if (run_reg && rtc_tick) begin
      if (sub_reg == SUB_LAST) begin
        sub_next  = '0;
        busy_next = 1'b0;
        ev_sec    = 1'b1;
        sec_next  = sec_reg + 6'h01;
        if (sec_reg == 6'd59) begin
          sec_next = 6'h00;
          ev_min   = 1'b1;
          min_next = min_reg + 6'h01;
          if (min_reg == 6'd59) begin
            min_next  = 6'h00;
            ev_hour   = 1'b1;
            hour_next = hour_reg + 5'h01;
            if (h24_reg && hour_reg == 5'd23) begin
              hour_next = 5'h00;
              ev_day    = 1'b1;
            end else if (!h24_reg && hour_reg == 5'd11) begin
              hour_next = 5'h00;
              pm_next   = ~pm_reg;
              ev_day    = pm_reg;
            end
            if (ev_day) begin
              dow_next = (dow_reg >= 3'd6) ? 3'h0 : dow_reg + 3'h1;
              ev_week  = (dow_next == 3'h0);
            end
          end
        end
      end else begin
        sub_next = sub_reg + 1'b1;
        if (sub_next == BUSY_START) begin
          busy_next = 1'b1;
        end
      end
    end

    set_flag = (ev_ovf  && pic_reg[`PIC_OVF_BIT])  ||
               (ev_week && pic_reg[`PIC_WEEK_BIT]) ||
               (ev_day  && pic_reg[`PIC_DAY_BIT])  ||
               (ev_hour && pic_reg[`PIC_HOUR_BIT]) ||
               (ev_min  && pic_reg[`PIC_MIN_BIT])  ||
               (ev_sec  && pic_reg[`PIC_SEC_BIT]);

    // Software writes win over the same-cycle advance of a time field
    if (wr_en) begin
      unique case (addr)
        `RTC_OFS_SECONDS: begin
          if (free_mode) begin
            frc_next = wdata;
          end else begin
            sec_next = wdata[5:0];
          end
        end
        `RTC_OFS_MINUTES:   min_next  = wdata[5:0];
        `RTC_OFS_HOURS:     hour_next = wdata[4:0];
        `RTC_OFS_WEEKDAY: begin
          if (wdata[2:0] != `WEEKDAY_BAD) begin
            dow_next = wdata[2:0];
          end
        end
        `RTC_OFS_MAIN_CTRL: begin
          run_next  = wdata[`MAIN_RUN_BIT];
          h24_next  = wdata[`MAIN_H24_BIT];
          pm_next   = wdata[`MAIN_PM_BIT];
          srst_next = wdata[`MAIN_SRST_BIT];
        end
        `RTC_OFS_PIC:       pic_next = wdata[5:0];
        `RTC_OFS_CSR:       csr_next = wdata & `CSR_MASK;
        `RTC_OFS_FLAG: begin
          if (!wdata[0]) begin
            flag_next = 1'b0;
          end
        end
      endcase
    end

    // A new event beats a clear in the same cycle
    if (set_flag) begin
      flag_next = 1'b1;
    end

    if (srst_reg) begin
      sec_next  = 6'h00;
      min_next  = 6'h00;
      hour_next = 5'h00;
      dow_next  = 3'h0;
      pm_next   = 1'b0;
      run_next  = 1'b0;
      h24_next  = 1'b0;
      pic_next  = `PIC_RESET;
      frc_next  = 8'h00;
      sub_next  = '0;
      busy_next = 1'b0;
    end

    if (rd_en) begin
      unique case (addr)
        `RTC_OFS_SECONDS:   rdata_next = free_mode ? frc_reg : {2'b00, sec_reg};
        `RTC_OFS_MINUTES:   rdata_next = {2'b00, min_reg};
        `RTC_OFS_HOURS:     rdata_next = {3'b000, hour_reg};
        `RTC_OFS_WEEKDAY:   rdata_next = {busy_reg, 4'h0, dow_reg};
        `RTC_OFS_MAIN_CTRL: rdata_next = {run_reg, h24_reg, pm_reg, srst_reg, 4'h0};
        `RTC_OFS_PIC:       rdata_next = {2'b00, pic_reg};
        `RTC_OFS_CSR:       rdata_next = csr_reg;
        `RTC_OFS_FLAG:      rdata_next = {7'h00, flag_reg};
      endcase
    end

    // Pin idles low outside active or sleep or when not routed
    clkout_next = clkout_pin_en && chip_active && pre.clkout_level;
  end

  always_ff @(posedge core_clk) begin
    if (ce) begin
      sec_reg  <= sec_next;
      min_reg  <= min_next;
      hour_reg <= hour_next;
      dow_reg  <= dow_next;
      pm_reg   <= pm_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      run_reg    <= 1'b0;
      h24_reg    <= 1'b0;
      srst_reg   <= `MAIN_RESET;
      pic_reg    <= `PIC_RESET;
      csr_reg    <= `CSR_RESET;
      frc_reg    <= 8'h00;
      sub_reg    <= '0;
      busy_reg   <= 1'b0;
      flag_reg   <= 1'b0;
      rdata_reg  <= 8'h00;
      clkout_reg <= 1'b0;
    end else if (ce) begin
      run_reg    <= run_next;
      h24_reg    <= h24_next;
      srst_reg   <= srst_next;
      pic_reg    <= pic_next;
      csr_reg    <= csr_next;
      frc_reg    <= frc_next;
      sub_reg    <= sub_next;
      busy_reg   <= busy_next;
      flag_reg   <= flag_next;
      rdata_reg  <= rdata_next;
      clkout_reg <= clkout_next;
    end
  end

  assign rdata            = rdata_reg;
  assign clock_output_pin = clkout_reg;
  assign clock_irq_flag   = flag_reg;
  assign update_busy_flag = busy_reg;
endmodule
`default_nettype wire

//--- test/rtc_irq_clock_select_asserts.sv
// Port-level checks of the clock block
`timescale 1ns/1ps
`default_nettype none
`include "rtc_cfg.svh"
module rtc_irq_clock_select_asserts (
  input wire logic           core_clk,
  input wire logic           rst,
  input wire logic           ce,
  input wire rtc_pkg::addr_t addr,
  input wire rtc_pkg::byte_t wdata,
  input wire logic           wr_en,
  input wire logic           rd_en,
  input wire rtc_pkg::byte_t rdata,
  input wire logic           rtc_tick,
  input wire logic           chip_active,
  input wire logic           clkout_pin_en,
  input wire logic           clock_output_pin,
  input wire logic           clock_irq_flag,
  input wire logic           update_busy_flag
);
  import rtc_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  a_pic_reserved_zero: assert property (rd_en && ce && addr == `RTC_OFS_PIC |=> rdata[7:6] == 2'h0)
    else $error("control reserved bits set");
  a_csr_reserved_zero: assert property (rd_en && ce && addr == `RTC_OFS_CSR |=> (rdata & ~`CSR_MASK) == 8'h00)
    else $error("source reserved bits set");
  a_weekday_busy_bit: assert property (rd_en && ce && addr == `RTC_OFS_WEEKDAY |=>
    rdata[7] == $past(update_busy_flag) && rdata[6:3] == 4'h0)
    else $error("weekday read bad busy bit");
  a_busy_on_tick: assert property ($rose(update_busy_flag) |-> $past(rtc_tick))
    else $error("busy rose without tick");
  a_busy_min_hold: assert property ($rose(update_busy_flag) |-> update_busy_flag[*3])
    else $error("busy too short");
  a_flag_sticky: assert property (clock_irq_flag && !(wr_en && addr == `RTC_OFS_FLAG && !wdata[0])
    |=> clock_irq_flag)
    else $error("flag dropped by itself");
  a_pin_gated: assert property (ce && !(chip_active && clkout_pin_en) |=> !clock_output_pin)
    else $error("clock out outside mode");
  a_pin_half_period: assert property ($rose(clock_output_pin) && ce && chip_active && clkout_pin_en &&
    !$past(wr_en && addr == `RTC_OFS_CSR) &&
    $past(ce && chip_active && clkout_pin_en && !(wr_en && addr == `RTC_OFS_CSR), 2) |=> clock_output_pin)
    else $error("clock out high too short");
  c_flag: cover property ($rose(clock_irq_flag));
  c_busy: cover property ($fell(update_busy_flag));
  c_pin: cover property ($rose(clock_output_pin));
endmodule
bind rtc_irq_clock_select rtc_irq_clock_select_asserts rtc_irq_clock_select_asserts_inst (
  .core_clk(core_clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
  .rdata(rdata), .rtc_tick(rtc_tick), .chip_active(chip_active), .clkout_pin_en(clkout_pin_en),
  .clock_output_pin(clock_output_pin), .clock_irq_flag(clock_irq_flag), .update_busy_flag(update_busy_flag));
`default_nettype wire

//--- test/rtc_irq_clock_select_test.sv
// Register-level bench of the clock block
`timescale 1ns/1ps
`default_nettype none
`include "rtc_cfg.svh"
module rtc_irq_clock_select_test;
  import rtc_pkg::*;
  logic  core_clk, rst, ce, wr_en, rd_en, rtc_tick;
  logic  chip_active, clkout_pin_en, clock_output_pin;
  logic  clock_irq_flag, update_busy_flag;
  addr_t addr;
  byte_t wdata, rdata;
  int    bad_count, check_count, n;
  // Short second keeps the run small
  rtc_irq_clock_select #(.TICKS_PER_SEC(64), .BUSY_TICKS(4)) rtc_irq_clock_select_inst (
    .core_clk(core_clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .rtc_tick(rtc_tick), .chip_active(chip_active), .clkout_pin_en(clkout_pin_en),
    .clock_output_pin(clock_output_pin), .clock_irq_flag(clock_irq_flag), .update_busy_flag(update_busy_flag));
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input byte_t exp, input byte_t got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input addr_t a, input byte_t d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
    #1;
  endtask
  task automatic rd(input addr_t a, input byte_t exp);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1;
    chk("rdata", exp, rdata);
  endtask
  task automatic ticks(input int k);
    repeat (k) begin
      rtc_tick <= 1'b1;
      @(posedge core_clk);
      rtc_tick <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
    #1;
  endtask
  task automatic wait_flag;
    for (n = 0; n < 200 && clock_irq_flag !== 1'b1; n++)
      @(posedge core_clk) #1;
    if (n == 200) begin
      bad_count++;
      close_out();
    end
  endtask
  // Whole periods only, so the rise count is exact
  task automatic pin_rises(input int code);
    logic prev;
    wr(`RTC_OFS_CSR, 8'h08 | byte_t'(code << `CSR_OUT_LSB));
    repeat (40) @(posedge core_clk) #1;
    n = 0;
    repeat (64) begin
      prev = clock_output_pin;
      @(posedge core_clk) #1;
      n += int'(clock_output_pin && !prev);
    end
    chk("clock out rises", byte_t'(64 / (4 << code)), byte_t'(n));
  endtask
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    {rst, ce, wr_en, rd_en, rtc_tick, chip_active, clkout_pin_en} = 7'h60;
    addr = 3'h0;
    wdata = 8'h00;
    bad_count = 0;
    check_count = 0;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk) #1;
    rd(`RTC_OFS_CSR, `CSR_RESET);
    rd(`RTC_OFS_PIC, 8'h00);
    wr(`RTC_OFS_PIC, 8'hc1);
    rd(`RTC_OFS_PIC, 8'h01);
    wr(`RTC_OFS_CSR, 8'hff);
    rd(`RTC_OFS_CSR, `CSR_MASK);
    wr(`RTC_OFS_MAIN_CTRL, 8'h10);
    wr(`RTC_OFS_MAIN_CTRL, 8'h00);
    rd(`RTC_OFS_PIC, 8'h00);
    rd(`RTC_OFS_CSR, `CSR_MASK);
    wr(`RTC_OFS_WEEKDAY, 8'h05);
    wr(`RTC_OFS_WEEKDAY, 8'h07);
    rd(`RTC_OFS_WEEKDAY, 8'h05);
    chip_active <= 1'b1;
    clkout_pin_en <= 1'b1;
    for (int c = 0; c < 4; c++) pin_rises(c);
    chip_active <= 1'b0;
    repeat (3) @(posedge core_clk) #1;
    chk("clock out idle", 8'h00, {7'h0, clock_output_pin});
    wr(`RTC_OFS_CSR, 8'h00);
    wr(`RTC_OFS_PIC, 8'h20);
    wr(`RTC_OFS_SECONDS, 8'hfc);
    wr(`RTC_OFS_MAIN_CTRL, 8'h80);
    wait_flag();
    rd(`RTC_OFS_SECONDS, 8'h00);
    wr(`RTC_OFS_FLAG, 8'h01);
    rd(`RTC_OFS_FLAG, 8'h01);
    wr(`RTC_OFS_FLAG, 8'h00);
    rd(`RTC_OFS_FLAG, 8'h00);
    wr(`RTC_OFS_PIC, 8'h00);
    wr(`RTC_OFS_SECONDS, 8'hfe);
    repeat (40) @(posedge core_clk) #1;
    rd(`RTC_OFS_FLAG, 8'h00);
    wr(`RTC_OFS_MAIN_CTRL, 8'h00);
    wr(`RTC_OFS_SECONDS, 8'h40);
    repeat (40) @(posedge core_clk) #1;
    rd(`RTC_OFS_SECONDS, 8'h40);
    wr(`RTC_OFS_CSR, 8'h08);
    wr(`RTC_OFS_MAIN_CTRL, 8'h10);
    wr(`RTC_OFS_MAIN_CTRL, 8'h00);
    wr(`RTC_OFS_SECONDS, 8'h05);
    wr(`RTC_OFS_PIC, 8'h01);
    wr(`RTC_OFS_MAIN_CTRL, 8'h80);
    ticks(63);
    chk("busy", 8'h01, {7'h0, update_busy_flag});
    rd(`RTC_OFS_SECONDS, 8'h05);
    ticks(1);
    rd(`RTC_OFS_SECONDS, 8'h06);
    rd(`RTC_OFS_FLAG, 8'h01);
    chk("busy", 8'h00, {7'h0, update_busy_flag});
    rd(`RTC_OFS_MINUTES, 8'h00);
    wr(`RTC_OFS_MAIN_CTRL, 8'h00);
    wr(`RTC_OFS_FLAG, 8'h00);
    wr(`RTC_OFS_PIC, 8'h10);
    wr(`RTC_OFS_SECONDS, 8'h3b);
    wr(`RTC_OFS_MINUTES, 8'h3b);
    wr(`RTC_OFS_HOURS, 8'h17);
    wr(`RTC_OFS_WEEKDAY, 8'h06);
    wr(`RTC_OFS_MAIN_CTRL, 8'hc0);
    rd(`RTC_OFS_FLAG, 8'h00);
    ticks(64);
    rd(`RTC_OFS_WEEKDAY, 8'h00);
    rd(`RTC_OFS_FLAG, 8'h01);
    // Twelve-hour wrap from pm to am counts a day
    wr(`RTC_OFS_MAIN_CTRL, 8'h00);
    wr(`RTC_OFS_FLAG, 8'h00);
    wr(`RTC_OFS_PIC, 8'h08);
    wr(`RTC_OFS_SECONDS, 8'h3b);
    wr(`RTC_OFS_MINUTES, 8'h3b);
    wr(`RTC_OFS_HOURS, 8'h0b);
    wr(`RTC_OFS_MAIN_CTRL, 8'ha0);
    ticks(64);
    rd(`RTC_OFS_HOURS, 8'h00);
    rd(`RTC_OFS_MAIN_CTRL, 8'h80);
    rd(`RTC_OFS_WEEKDAY, 8'h01);
    rd(`RTC_OFS_FLAG, 8'h01);
    wr(`RTC_OFS_MINUTES, 8'h2a);
    rst <= 1'b1;
    @(posedge core_clk) #1;
    rst <= 1'b0;
    @(posedge core_clk) #1;
    rd(`RTC_OFS_MINUTES, 8'h2a);
    // Write while frozen must not land
    ce <= 1'b0;
    wr(`RTC_OFS_PIC, 8'h20);
    ce <= 1'b1;
    rd(`RTC_OFS_PIC, 8'h00);
    close_out();
  end
endmodule
`default_nettype wire
